// File: design/era_status.sv
// Purpose: E1 receive alignment status, capture bytes and supervision timers.
// Assumes: Framer core supplies alignment levels and per-frame strobes on mclk.
// Notes:   Registers read over AXI4-Lite; writes are answered but ignored.
`timescale 1ns/1ns
`include "era_map.svh"
module era_status
	import era_pkg::*;
#(
	parameter int MS_CYCLES = `ERA_MS_NS / `ERA_CLK_NS
)(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire era_line_t   line_in,
	input  wire era_ts0_t    ts0_in,
	input  wire logic        maint_opt,
	input  wire logic        auto_iwk,
	output logic             force_reframe,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	//--------------------------------------------------------------
	// Millisecond tick
	//--------------------------------------------------------------
	logic [31:0] ms_cnt_reg;
	logic        ms_tick;
	logic [1:0]  ebit_reg;
	logic        prev_crc_lost_reg;
	logic        ms_resync;
	assign ms_tick   = (ms_cnt_reg == 32'(MS_CYCLES - 1));
	assign ms_resync = !line_in.crc_lost && line_in.crc_sync_pulse;
	always_ff @(posedge mclk) begin
		if (rst || ms_tick || ms_resync) begin
			ms_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 32'h1;
		end
	end

	//--------------------------------------------------------------
	// Persistence counters in milliseconds
	//--------------------------------------------------------------
	logic [9:0] red_ms_reg;
	logic [9:0] t1_ms_reg;
	logic [9:0] t2_ms_reg;
	logic [9:0] klv_ms_reg;
	logic [9:0] rf_ms_reg;
	logic       red_reg;
	logic       t1_reg;
	logic       t2_reg;
	logic       klv_reg;
	logic       reframe_reg;
	logic       rf_armed_reg;
	logic       t2_rise;

	function automatic logic [9:0] persist(input logic cond, input logic [9:0] cnt,
		input logic [9:0] lim);
		if (!cond) begin
			persist = '0;
		end else if (ms_tick && cnt < lim) begin
			persist = cnt + 10'h1;
		end else begin
			persist = cnt;
		end
	endfunction

	always_ff @(posedge mclk) begin
		if (rst) begin
			red_ms_reg <= '0;
			red_reg    <= 1'b0;
		end else begin
			red_ms_reg <= persist(line_in.fas_lost, red_ms_reg, 10'(`ERA_TMO_RED_MS));
			red_reg    <= line_in.fas_lost && (red_ms_reg >= 10'(`ERA_TMO_RED_MS));
		end
	end

	assign t2_rise = !t2_reg && !line_in.nonnormal && !line_in.fas_lost &&
		(t2_ms_reg >= 10'(`ERA_TMO_T2_MS));
	always_ff @(posedge mclk) begin
		if (rst) begin
			t1_ms_reg <= '0;
			t1_reg    <= 1'b0;
		end else begin
			t1_ms_reg <= persist(line_in.nonnormal, t1_ms_reg, 10'(`ERA_TMO_T1_MS));
			if (t2_rise) begin
				t1_reg <= 1'b0;
			end else if (line_in.nonnormal && t1_ms_reg >= 10'(`ERA_TMO_T1_MS)) begin
				t1_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			t2_ms_reg <= '0;
			t2_reg    <= 1'b0;
		end else begin
			t2_ms_reg <= persist(!line_in.nonnormal && !line_in.fas_lost, t2_ms_reg,
				10'(`ERA_TMO_T2_MS));
			if (line_in.nonnormal) begin
				t2_reg <= 1'b0;
			end else if (t2_rise) begin
				t2_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			klv_ms_reg <= '0;
			klv_reg    <= 1'b0;
		end else begin
			klv_ms_reg <= persist(line_in.ais, klv_ms_reg, 10'(`ERA_TMO_KLV_MS));
			klv_reg    <= line_in.ais && (klv_ms_reg >= 10'(`ERA_TMO_KLV_MS));
		end
	end

	// Reframe search window opens when basic sync is gained
	always_ff @(posedge mclk) begin
		if (rst || line_in.fas_lost) begin
			rf_ms_reg    <= '0;
			rf_armed_reg <= 1'b1;
			reframe_reg  <= 1'b0;
		end else if (!line_in.crc_lost) begin
			rf_armed_reg <= 1'b0;
			reframe_reg  <= 1'b0;
		end else if (rf_armed_reg) begin
			rf_ms_reg <= persist(1'b1, rf_ms_reg, 10'(`ERA_TMO_REFRAME_MS));
			if (rf_ms_reg >= 10'(`ERA_TMO_REFRAME_MS)) begin
				reframe_reg  <= 1'b1;
				rf_armed_reg <= 1'b0;
			end
		end
	end
	assign force_reframe = reframe_reg && maint_opt && !auto_iwk;

	//--------------------------------------------------------------
	// Toggle timers
	//--------------------------------------------------------------
	logic [9:0] half_ms_reg;
	logic [9:0] long_ms_reg;
	logic [3:0] short_ms_reg;
	logic       half_reg;
	logic       one_reg;
	logic       t400_reg;
	logic       t8_reg;
	logic       ms_tog_reg;
	always_ff @(posedge mclk) begin
		if (rst) begin
			half_ms_reg <= '0;
			half_reg    <= 1'b0;
			one_reg     <= 1'b0;
		end else if (ms_tick) begin
			if (half_ms_reg == 10'(`ERA_HALF_SEC_MS - 1)) begin
				half_ms_reg <= '0;
				half_reg    <= !half_reg;
				if (half_reg) begin
					one_reg <= !one_reg;
				end
			end else begin
				half_ms_reg <= half_ms_reg + 10'h1;
			end
		end
	end

	// CRC-4 alignment timers restart when CRC-4 alignment is lost
	always_ff @(posedge mclk) begin
		prev_crc_lost_reg <= rst ? 1'b1 : line_in.crc_lost;
		if (rst) begin
			long_ms_reg  <= '0;
			short_ms_reg <= '0;
			t400_reg     <= 1'b0;
			t8_reg       <= 1'b0;
			ms_tog_reg   <= 1'b0;
		end else begin
			if (ms_tick || ms_resync) begin
				ms_tog_reg <= !ms_tog_reg;
			end
			if (line_in.crc_lost && !prev_crc_lost_reg) begin
				long_ms_reg  <= '0;
				short_ms_reg <= '0;
			end else if (ms_tick) begin
				if (long_ms_reg == 10'(`ERA_TMO_LONG_MS - 1)) begin
					long_ms_reg <= '0;
					t400_reg    <= !t400_reg;
				end else begin
					long_ms_reg <= long_ms_reg + 10'h1;
				end
				if (short_ms_reg == 4'(`ERA_TMO_SHORT_MS - 1)) begin
					short_ms_reg <= '0;
					t8_reg       <= !t8_reg;
				end else begin
					short_ms_reg <= short_ms_reg + 4'h1;
				end
			end
		end
	end

	//--------------------------------------------------------------
	// Time slot 0 capture
	//--------------------------------------------------------------
	logic [7:0] fas_reg;
	logic [7:0] nfas_reg;
	always_ff @(posedge mclk) begin
		if (rst) begin
			fas_reg  <= '0;
			nfas_reg <= '0;
			ebit_reg <= '0;
		end else begin
			if (ts0_in.fas_valid) begin
				fas_reg <= ts0_in.ts0_byte;
			end
			if (ts0_in.nfas_valid) begin
				nfas_reg <= ts0_in.ts0_byte;
			end
			if (line_in.mframe_end) begin
				ebit_reg <= line_in.ebits;
			end
		end
	end

	//--------------------------------------------------------------
	// Register views
	//--------------------------------------------------------------
	logic [7:0] sync_view;
	logic [7:0] timer_view;
	always_comb begin
		sync_view                    = '0;
		sync_view[`ERA_BIT_FAS_LOST] = line_in.fas_lost;
		sync_view[`ERA_BIT_MF_LOST]  = line_in.mf_lost;
		sync_view[`ERA_BIT_CRC_LOST] = line_in.crc_lost;
		sync_view[`ERA_BIT_EBIT1]    = ebit_reg[1];
		sync_view[`ERA_BIT_EBIT2]    = ebit_reg[0];
		sync_view[`ERA_BIT_REFRAME]  = reframe_reg;
		sync_view[`ERA_BIT_RED]      = red_reg;
		sync_view[`ERA_BIT_IWK]      = line_in.iwk_crc;
		timer_view                   = '0;
		timer_view[`ERA_BIT_HALF]    = half_reg;
		timer_view[`ERA_BIT_ONE]     = one_reg;
		timer_view[`ERA_BIT_T1]      = t1_reg;
		timer_view[`ERA_BIT_T2]      = t2_reg;
		timer_view[`ERA_BIT_T400]    = t400_reg;
		timer_view[`ERA_BIT_T8]      = t8_reg;
		timer_view[`ERA_BIT_MS]      = ms_tog_reg;
		timer_view[`ERA_BIT_KLV]     = klv_reg;
	end

	function automatic logic [8:0] reg_lookup(input logic [31:0] addr, input logic [7:0] sv,
		input logic [7:0] fv, input logic [7:0] tv, input logic [7:0] nv);
		reg_lookup = {1'b0, 8'h00};
		if (addr[1:0] == 2'h0 && addr[31:10] == '0) begin
			unique case (addr[9:2])
				`ERA_IDX_SYNC:  reg_lookup = {1'b1, sv};
				`ERA_IDX_FAS:   reg_lookup = {1'b1, fv};
				`ERA_IDX_TIMER: reg_lookup = {1'b1, tv};
				`ERA_IDX_NFAS:  reg_lookup = {1'b1, nv};
				default:        reg_lookup = {1'b0, 8'h00};
			endcase
		end
	endfunction

	//--------------------------------------------------------------
	// AXI4-Lite read channel
	//--------------------------------------------------------------
	era_rd_state_t rd_state_reg;
	logic [8:0]    rd_hit;
	assign rd_hit        = reg_lookup(s_axi_araddr, sync_view, fas_reg, timer_view, nfas_reg);
	assign s_axi_arready = (rd_state_reg == ERA_RD_IDLE);
	assign s_axi_rvalid  = (rd_state_reg == ERA_RD_RESP);
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_state_reg <= ERA_RD_IDLE;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `ERA_RESP_OKAY;
		end else begin
			unique case (rd_state_reg)
				ERA_RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_reg <= ERA_RD_RESP;
						s_axi_rdata  <= {24'h000000, rd_hit[7:0]};
						s_axi_rresp  <= rd_hit[8] ? `ERA_RESP_OKAY : `ERA_RESP_SLVERR;
					end
				end
				ERA_RD_RESP: begin
					if (s_axi_rready) begin
						rd_state_reg <= ERA_RD_IDLE;
					end
				end
				default: rd_state_reg <= ERA_RD_IDLE;
			endcase
		end
	end

	//--------------------------------------------------------------
	// AXI4-Lite write channel, writes discarded
	//--------------------------------------------------------------
	era_wr_state_t wr_state_reg;
	logic          aw_seen_reg;
	logic          w_seen_reg;
	logic          aw_ok_reg;
	logic          aw_ok_now;
	assign aw_ok_now     = reg_lookup(s_axi_awaddr, 8'h00, 8'h00, 8'h00, 8'h00) >> 8 != 9'h0;
	assign s_axi_awready = (wr_state_reg == ERA_WR_IDLE) && !aw_seen_reg;
	assign s_axi_wready  = (wr_state_reg == ERA_WR_IDLE) && !w_seen_reg;
	assign s_axi_bvalid  = (wr_state_reg == ERA_WR_RESP);
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_state_reg <= ERA_WR_IDLE;
			aw_seen_reg  <= 1'b0;
			w_seen_reg   <= 1'b0;
			aw_ok_reg    <= 1'b0;
			s_axi_bresp  <= `ERA_RESP_OKAY;
		end else begin
			unique case (wr_state_reg)
				ERA_WR_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_seen_reg <= 1'b1;
						aw_ok_reg   <= aw_ok_now;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_seen_reg <= 1'b1;
					end
					if ((aw_seen_reg || s_axi_awvalid) && (w_seen_reg || s_axi_wvalid)) begin
						wr_state_reg <= ERA_WR_RESP;
						aw_seen_reg  <= 1'b0;
						w_seen_reg   <= 1'b0;
						// Read-only map: a mapped write is acknowledged and dropped
						s_axi_bresp  <= (aw_seen_reg ? aw_ok_reg : aw_ok_now) ?
							`ERA_RESP_OKAY : `ERA_RESP_SLVERR;
					end
				end
				ERA_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_reg <= ERA_WR_IDLE;
					end
				end
				default: wr_state_reg <= ERA_WR_IDLE;
			endcase
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	red_after_loss_a: assert property (!line_in.fas_lost |=> !red_reg)
		else $error("alarm stayed up after alignment regained");
	klv_drop_a: assert property (!line_in.ais |=> !klv_reg)
		else $error("keep-alive stayed up without AIS");
	t2_clear_a: assert property (line_in.nonnormal |=> !t2_reg)
		else $error("terminal sync timer not cleared");
	t1_clear_a: assert property (t2_rise |=> !t1_reg && t2_reg)
		else $error("non-normal timer not cleared by terminal sync");
	half_step_a: assert property ($rose(one_reg) |-> $changed(half_reg))
		else $error("one second toggle out of step");
	half_tog_a: assert property (ms_tick && half_ms_reg == 10'(`ERA_HALF_SEC_MS - 1)
		|=> $changed(half_reg))
		else $error("half second toggle missed");
	long_tog_a: assert property (ms_tick && long_ms_reg == 10'(`ERA_TMO_LONG_MS - 1)
		&& !(line_in.crc_lost && !prev_crc_lost_reg) |=> $changed(t400_reg))
		else $error("long timer toggle missed");
	short_tog_a: assert property (ms_tick && short_ms_reg == 4'(`ERA_TMO_SHORT_MS - 1)
		&& !(line_in.crc_lost && !prev_crc_lost_reg) |=> $changed(t8_reg))
		else $error("short timer toggle missed");
	ms_tog_a: assert property (ms_resync |=> $changed(ms_tog_reg) && ms_cnt_reg == 0)
		else $error("ms toggle not realigned");
	fas_cap_a: assert property (ts0_in.fas_valid |=> fas_reg == $past(ts0_in.ts0_byte))
		else $error("alignment byte not captured");
	nfas_cap_a: assert property (ts0_in.nfas_valid |=> nfas_reg == $past(ts0_in.ts0_byte))
		else $error("non-alignment byte not captured");
	frc_rf_a: assert property (force_reframe |-> reframe_reg && !auto_iwk)
		else $error("reframe forced without cause");
	red_cov_c: cover property ($rose(red_reg));
	t2_cov_c: cover property ($rose(t2_reg));
	rf_cov_c: cover property ($rose(reframe_reg));
	rd_cov_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// File: design/era_map.svh
// Purpose: Register map, field positions and timing constants for the E1 receive
//          alignment status block.
// Assumes: 100 MHz mclk, 32-bit AXI4-Lite register access.
// Notes:   Register offsets below are word indexes; byte address is four times the index.
`ifndef ERA_MAP_SVH
`define ERA_MAP_SVH
`define ERA_IDX_SYNC        8'h10
`define ERA_IDX_FAS         8'h11
`define ERA_IDX_TIMER       8'h12
`define ERA_IDX_NFAS        8'h13
`define ERA_BIT_FAS_LOST    7
`define ERA_BIT_MF_LOST     6
`define ERA_BIT_CRC_LOST    5
`define ERA_BIT_EBIT1       4
`define ERA_BIT_EBIT2       3
`define ERA_BIT_REFRAME     2
`define ERA_BIT_RED         1
`define ERA_BIT_IWK         0
`define ERA_BIT_HALF        7
`define ERA_BIT_ONE         6
`define ERA_BIT_T1          5
`define ERA_BIT_T2          4
`define ERA_BIT_T400        3
`define ERA_BIT_T8          2
`define ERA_BIT_MS          1
`define ERA_BIT_KLV         0
`define ERA_CLK_NS          10
`define ERA_MS_NS           1000000
`define ERA_TMO_REFRAME_MS  8
`define ERA_TMO_RED_MS      100
`define ERA_TMO_T1_MS       100
`define ERA_TMO_T2_MS       10
`define ERA_TMO_LONG_MS     400
`define ERA_TMO_SHORT_MS    8
`define ERA_TMO_KLV_MS      100
`define ERA_HALF_SEC_MS     500
`define ERA_FAS_PATTERN     7'h1B
`define ERA_RESP_OKAY       2'h0
`define ERA_RESP_SLVERR     2'h2
`endif

// File: design/era_pkg.sv
// Purpose: Types for the E1 receive alignment status block.
// Assumes: None.
// Notes:   Carriers for framer events and the register bus.
package era_pkg;
	typedef struct packed {
		logic       fas_lost;
		logic       mf_lost;
		logic       crc_lost;
		logic       crc_sync_pulse;
		logic       mframe_end;
		logic [1:0] ebits;
		logic       nonnormal;
		logic       ais;
		logic       iwk_crc;
	} era_line_t;
	typedef struct packed {
		logic       fas_valid;
		logic       nfas_valid;
		logic [7:0] ts0_byte;
	} era_ts0_t;
	typedef enum logic [1:0] {ERA_RD_IDLE, ERA_RD_RESP} era_rd_state_t;
	typedef enum logic [1:0] {ERA_WR_IDLE, ERA_WR_RESP} era_wr_state_t;
endpackage

// File: bench/era_far_end.sv
// Purpose: Far-end PCM 30 line model feeding the alignment status block.
// Assumes: Tasks are called just after a rising mclk edge.
// Notes:   Strobed fields are scrambled once their strobe drops.
`timescale 1ns/1ns
module era_far_end
	import era_pkg::*;
(
	input  wire logic mclk,
	output era_line_t line_in,
	output era_ts0_t  ts0_in
);
	initial begin
		line_in = '0;
		line_in.fas_lost = 1'b1;
		ts0_in = '0;
	end

	// Levels settle one edge before the caller reads any view of them
	task automatic set_line(input logic fl, mf, cl, nn, ais, iwk);
		line_in.fas_lost <= fl;
		line_in.mf_lost <= mf;
		line_in.crc_lost <= cl;
		line_in.nonnormal <= nn;
		line_in.ais <= ais;
		line_in.iwk_crc <= iwk;
		@(posedge mclk);
	endtask

	// One frame strobe; bit 6 forced high on non-alignment frames
	task automatic pulse_ts0(input logic nfas, input logic [7:0] b);
		ts0_in.fas_valid <= !nfas;
		ts0_in.nfas_valid <= nfas;
		ts0_in.ts0_byte <= nfas ? (b | 8'h40) : b;
		@(posedge mclk);
		ts0_in <= '{1'b0, 1'b0, ~b};
		@(posedge mclk);
	endtask

	// Multiframe end with E-bits, or CRC-4 sync pulse
	task automatic pulse_line(input logic mfe, input logic [1:0] eb);
		line_in.mframe_end <= mfe;
		line_in.crc_sync_pulse <= !mfe;
		line_in.ebits <= eb;
		@(posedge mclk);
		line_in.mframe_end <= 1'b0;
		line_in.crc_sync_pulse <= 1'b0;
		line_in.ebits <= ~eb;
		@(posedge mclk);
	endtask
endmodule

// File: bench/era_status_bench.sv
// Purpose: Self-checking bench for the E1 receive alignment status block.
// Assumes: MS_CYCLES shortened to 20 clocks per millisecond.
// Notes:   Registers reached over AXI4-Lite; timers judged by polling.
`timescale 1ns/1ns
`include "era_map.svh"
module e1_receive_alignment_status_bench
	import era_pkg::*;
;
	localparam int MS = 20;
	localparam logic [31:0] A_SYNC = 32'h4 * `ERA_IDX_SYNC;
	localparam logic [31:0] A_FAS = 32'h4 * `ERA_IDX_FAS;
	localparam logic [31:0] A_TMR = 32'h4 * `ERA_IDX_TIMER;
	localparam logic [31:0] A_NFAS = 32'h4 * `ERA_IDX_NFAS;
	logic mclk, rst, maint_opt, auto_iwk, force_reframe;
	era_line_t line_in;
	era_ts0_t ts0_in;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] prev, dif;
	int failures, checks_done, cyc, t0, bad;
	int cnt[8];

	era_status #(.MS_CYCLES(MS)) u_dut (.mclk, .rst, .line_in, .ts0_in, .maint_opt,
		.auto_iwk, .force_reframe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	era_far_end u_far (.mclk(mclk), .line_in(line_in), .ts0_in(ts0_in));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
		checks_done++;
		if (g < lo || g > hi) begin
			failures++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic rd_reg(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge mclk);
			if (s_axi_awready === 1'b1) aw = 1'b1;
			if (s_axi_wready === 1'b1) w = 1'b1;
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [7:0] m,
		input logic [7:0] e);
		rd_reg(a);
		cmp("rresp", `ERA_RESP_OKAY, {30'h0, rs});
		cmp(nm, {24'h0, e}, rd & {24'hFFFFFF, m});
	endtask
	task automatic wait_ms(input int n);
		repeat (n * MS) @(posedge mclk);
	endtask
	task automatic close_out;
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		close_out;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, maint_opt, auto_iwk} = 3'b110;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		{failures, checks_done, cyc, bad} = '0;
		foreach (cnt[i]) cnt[i] = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd_chk("sync", A_SYNC, 8'hFF, 8'h80);
		rd_chk("fas", A_FAS, 8'hFF, 8'h00);
		rd_chk("nfas", A_NFAS, 8'hFF, 8'h00);
		u_far.set_line(1, 1, 1, 0, 0, 1);
		u_far.pulse_line(1, 2'b10);
		rd_chk("sync", A_SYNC, 8'hFF, 8'hF1);
		u_far.set_line(1, 0, 0, 0, 0, 0);
		u_far.pulse_line(1, 2'b01);
		rd_chk("sync", A_SYNC, 8'hFF, 8'h88);
		u_far.set_line(1, 0, 0, 1, 1, 0);
		wait_ms(98);
		rd_chk("red", A_SYNC, 8'h02, 8'h00);
		rd_chk("t1klv", A_TMR, 8'h21, 8'h00);
		wait_ms(4);
		rd_chk("red", A_SYNC, 8'h02, 8'h02);
		rd_chk("t1klv", A_TMR, 8'h31, 8'h21);
		u_far.set_line(0, 0, 1, 0, 0, 0);
		rd_chk("red", A_SYNC, 8'h02, 8'h00);
		rd_chk("klv", A_TMR, 8'h01, 8'h00);
		wait_ms(6);
		rd_chk("refr", A_SYNC, 8'h04, 8'h00);
		rd_chk("t2", A_TMR, 8'h30, 8'h20);
		wait_ms(6);
		rd_chk("refr", A_SYNC, 8'h04, 8'h04);
		cmp("force_reframe", 32'h1, {31'h0, force_reframe});
		rd_chk("t1t2", A_TMR, 8'h30, 8'h10);
		auto_iwk <= 1'b1;
		repeat (2) @(posedge mclk);
		cmp("force_reframe", 32'h0, {31'h0, force_reframe});
		{auto_iwk, maint_opt} <= 2'b00;
		repeat (2) @(posedge mclk);
		cmp("force_reframe", 32'h0, {31'h0, force_reframe});
		maint_opt <= 1'b1;
		// CRC-4 sync regained, then a sync pulse realigns the ms toggle
		u_far.set_line(0, 0, 0, 0, 0, 0);
		u_far.pulse_line(0, 2'b00);
		rd_chk("refr", A_SYNC, 8'h04, 8'h00);
		u_far.set_line(0, 0, 1, 1, 0, 0);
		rd_chk("t2", A_TMR, 8'h10, 8'h00);
		u_far.set_line(0, 0, 1, 0, 0, 0);
		u_far.pulse_ts0(0, 8'h9B);
		rd_chk("fas", A_FAS, 8'hFF, 8'h9B);
		u_far.pulse_ts0(0, 8'h1B);
		rd_chk("fas", A_FAS, 8'hFF, 8'h1B);
		u_far.pulse_ts0(1, 8'hA5);
		rd_chk("nfas", A_NFAS, 8'hFF, 8'hE5);
		u_far.pulse_ts0(1, 8'h1A);
		rd_chk("nfas", A_NFAS, 8'hFF, 8'h5A);
		rd_chk("fas", A_FAS, 8'hFF, 8'h1B);
		wr_reg(A_FAS, 32'hFF);
		cmp("bresp", `ERA_RESP_OKAY, {30'h0, rs});
		rd_chk("fas", A_FAS, 8'hFF, 8'h1B);
		wr_reg(32'h50, 32'h0);
		cmp("bresp", `ERA_RESP_SLVERR, {30'h0, rs});
		rd_reg(32'h50);
		cmp("rresp", `ERA_RESP_SLVERR, {30'h0, rs});
		cmp("rdata", 32'h0, rd);
		// Count timer toggles over one second of polling
		rd_reg(A_TMR);
		prev = rd[7:0];
		t0 = cyc;
		while (cyc - t0 < 1000 * MS) begin
			rd_reg(A_TMR);
			dif = rd[7:0] ^ prev;
			foreach (cnt[i]) cnt[i] += dif[i];
			if (dif[6] && !(dif[7] && prev[7])) bad++;
			prev = rd[7:0];
		end
		cmp_rng("half", 2, 3, cnt[7]);
		cmp_rng("one", 1, 2, cnt[6]);
		cmp_rng("step", 0, 0, bad);
		cmp_rng("t400", 2, 3, cnt[3]);
		cmp_rng("t8", 124, 126, cnt[2]);
		cmp_rng("ms", 998, 1002, cnt[1]);
		close_out;
	end
endmodule
